// ===== include/ccs_defs.svh
// Constants for the cross-connect switch control
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH
// Fabric size
`define CCS_NPORT     7168
`define CCS_PW        13
`define CCS_NDS3      256
`define CCS_STAGES    3
// Command queue
`define CCS_QDEPTH    16
`define CCS_TW        32
// Clock rate
`define CCS_CLK_MHZ   100
// Time limits as printed
`define CCS_SETUP_FAST_MS 1000
`define CCS_SETUP_SLOW_MS 3000
`define CCS_HIT_FAST_US   2000
`define CCS_HIT_SLOW_US   3000
`define CCS_IDLE_US       3000
// Cycle counts derived from the limits
`define CCS_US2CYC(t) ((t) * `CCS_CLK_MHZ)
`define CCS_MS2CYC(t) ((t) * 1000 * `CCS_CLK_MHZ)
`endif

// ===== include/ccs_pkg.sv
// Types for the cross-connect switch control
package ccs_pkg;
    typedef enum logic [2:0] {
        CCS_ONEWAY, CCS_TWOWAY, CCS_BRIDGE, CCS_ROLL,
        CCS_SPLIT, CCS_UNSPLIT, CCS_DISC
    } ccs_op_t;
    typedef enum logic [1:0] {
        CCS_DS1, CCS_VT15, CCS_STS1
    } ccs_sig_t;
    typedef enum logic [2:0] {
        CCS_OK, CCS_E_RANGE, CCS_E_BUSY, CCS_E_NOCONN,
        CCS_E_LATE, CCS_E_OP
    } ccs_err_t;
    typedef struct packed {
        ccs_op_t     op;
        ccs_sig_t    sig;
        logic [12:0] a;
        logic [12:0] b;
        logic [12:0] c;
        logic [12:0] d;
    } ccs_cmd_t;
    typedef struct packed {
        ccs_cmd_t    cmd;
        logic [31:0] stamp;
    } ccs_qword_t;
    typedef struct packed {
        logic        valid;
        logic        split;
        logic [12:0] src;
        logic [12:0] orig;
    } ccs_entry_t;
    typedef struct packed {
        logic        valid;
        logic        idle;
        logic [12:0] out;
        logic [12:0] src;
    } ccs_cfg_t;
    typedef struct packed {
        logic        valid;
        ccs_op_t     op;
        ccs_err_t    err;
        logic [31:0] elapsed;
    } ccs_rsp_t;
endpackage : ccs_pkg

// ===== design/ccs_switch_ctrl.sv
// Connection control for a three-stage space switch
// Operation
// [R1] Nonblocking: free input to free output succeeds
// [R2] 7168 input and 7168 output ports
// [R3] One-way, two-way, bridge and roll requests
// [R4] Setup under 1 s, STS-1 3 s
// [R5] Time from request receipt to path made
// [R6] Bridge adds output, existing path untouched
// [R7] Roll swaps path in one step
// [R8] Split to test ports, bounded hit
// [R9] Unsplit restores original path automatically
// [R10] Disconnect drives idle on the output
// [R11] Unnamed connections never change
`timescale 1ns/1ps
`include "ccs_defs.svh"

// ****************************************
// Command FIFO
// ****************************************
module ccs_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } ccs_fifo_st_t;
    ccs_fifo_st_t s;
    ccs_fifo_st_t next_s;
    logic         push;
    logic         pop;

    // Honest full and empty flags
    assign in_ready  = (s.cnt != (AW+1)'(D));
    assign out_valid = (s.cnt != '0);
    assign out_data  = s.mem[s.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and storage update
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
        end
        next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : ccs_fifo

// ****************************************
// Switch control top
// ****************************************
module ccs_switch_ctrl import ccs_pkg::*; #(
    parameter int SETUP_FAST = `CCS_MS2CYC(`CCS_SETUP_FAST_MS),
    parameter int SETUP_SLOW = `CCS_MS2CYC(`CCS_SETUP_SLOW_MS),
    parameter int HIT_FAST   = `CCS_US2CYC(`CCS_HIT_FAST_US),
    parameter int HIT_SLOW   = `CCS_US2CYC(`CCS_HIT_SLOW_US),
    parameter int IDLE_LIM   = `CCS_US2CYC(`CCS_IDLE_US)
) (
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire logic     cmd_valid,
    output logic          cmd_ready,
    input  wire ccs_cmd_t cmd,
    output ccs_rsp_t      rsp,
    output ccs_cfg_t      cfg0,
    output ccs_cfg_t      cfg1
);
    typedef enum logic {
        ST_IDLE, ST_EXEC
    } ccs_fsm_t;
    typedef struct packed {
        ccs_fsm_t                     fsm;
        ccs_qword_t                   cur;
        logic [`CCS_TW-1:0]           timer;
        ccs_cfg_t                     cfg0;
        ccs_cfg_t                     cfg1;
        ccs_rsp_t                     rsp;
        ccs_entry_t [`CCS_NPORT-1:0]  map;
    } ccs_st_t;

    ccs_st_t    s;
    ccs_st_t    next_s;
    ccs_qword_t q_in;
    ccs_qword_t q_out;
    logic       q_valid;
    logic       q_ready;

    // Port index in range
    function automatic logic in_rng(input logic [12:0] p);
        in_rng = (p < `CCS_PW'(`CCS_NPORT));
    endfunction : in_rng

    // Limit in cycles for an operation
    function automatic logic [`CCS_TW-1:0] lim(
        input ccs_op_t op, input ccs_sig_t sg);
        logic slow;
        slow = (sg == CCS_STS1);
        case (op)
            CCS_ROLL, CCS_SPLIT:
                lim = slow ? `CCS_TW'(HIT_SLOW) : `CCS_TW'(HIT_FAST);
            CCS_UNSPLIT:
                lim = `CCS_TW'(HIT_FAST);
            CCS_DISC:
                lim = `CCS_TW'(IDLE_LIM);
            default:
                lim = slow ? `CCS_TW'(SETUP_SLOW) : `CCS_TW'(SETUP_FAST);
        endcase
    endfunction : lim

    // Requests stamped on receipt
    // [R5] setup time start
    assign q_in.cmd   = cmd;
    assign q_in.stamp = s.timer;
    assign q_ready    = (s.fsm == ST_IDLE);

    ccs_fifo #(
        .W ($bits(ccs_qword_t)),
        .D (`CCS_QDEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (cmd_valid),
        .in_ready  (cmd_ready),
        .in_data   (q_in),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_out)
    );

    // Registered outputs
    assign rsp  = s.rsp;
    assign cfg0 = s.cfg0;
    assign cfg1 = s.cfg1;

    // Command execution
    always_comb begin
        ccs_cmd_t    c;
        ccs_entry_t  ea;
        ccs_entry_t  eb;
        ccs_entry_t  ec;
        ccs_err_t    err;
        logic [31:0] el;
        c   = s.cur.cmd;
        ea  = '0;
        eb  = '0;
        ec  = '0;
        err = CCS_OK;
        el  = s.timer - s.cur.stamp;
        next_s = s;
        next_s.timer = s.timer + 1'b1;
        next_s.cfg0  = '0;
        next_s.cfg1  = '0;
        next_s.rsp   = '0;
        case (s.fsm)
            ST_IDLE: begin
                if (q_valid) begin
                    next_s.cur = q_out;
                    next_s.fsm = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_s.fsm = ST_IDLE;
                // [R2] port range
                if (!in_rng(c.a) || !in_rng(c.b) || !in_rng(c.c) || !in_rng(c.d)) begin
                    err = CCS_E_RANGE;
                end else begin
                    ea = s.map[c.a];
                    eb = s.map[c.b];
                    ec = s.map[c.c];
                    // [R3] per-type behaviour
                    case (c.op)
                        // [R1] free ports always join
                        CCS_ONEWAY: begin
                            if (eb.valid) begin
                                err = CCS_E_BUSY;
                            end else begin
                                next_s.map[c.b] = {1'b1, 1'b0, c.a, c.a};
                                next_s.cfg0 = {1'b1, 1'b0, c.b, c.a};
                            end
                        end
                        CCS_TWOWAY: begin
                            if (eb.valid || ea.valid) begin
                                err = CCS_E_BUSY;
                            end else begin
                                next_s.map[c.b] = {1'b1, 1'b0, c.a, c.a};
                                next_s.map[c.a] = {1'b1, 1'b0, c.b, c.b};
                                next_s.cfg0 = {1'b1, 1'b0, c.b, c.a};
                                next_s.cfg1 = {1'b1, 1'b0, c.a, c.b};
                            end
                        end
                        // [R6] existing path kept
                        CCS_BRIDGE: begin
                            if (!ec.valid || ec.src != c.a) begin
                                err = CCS_E_NOCONN;
                            end else if (eb.valid) begin
                                err = CCS_E_BUSY;
                            end else begin
                                next_s.map[c.b] = {1'b1, 1'b0, c.a, c.a};
                                next_s.cfg0 = {1'b1, 1'b0, c.b, c.a};
                            end
                        end
                        // [R7] single step swap
                        CCS_ROLL: begin
                            if (!eb.valid) begin
                                err = CCS_E_NOCONN;
                            end else begin
                                next_s.map[c.b] = {1'b1, 1'b0, c.a, c.a};
                                next_s.cfg0 = {1'b1, 1'b0, c.b, c.a};
                            end
                        end
                        // [R8] route to test ports
                        CCS_SPLIT: begin
                            if (!eb.valid || eb.src != c.a || eb.split) begin
                                err = CCS_E_NOCONN;
                            end else if (ec.valid) begin
                                err = CCS_E_BUSY;
                            end else begin
                                next_s.map[c.c] = {1'b1, 1'b0, c.a, c.a};
                                next_s.map[c.b] = {1'b1, 1'b1, c.d, c.a};
                                next_s.cfg0 = {1'b1, 1'b0, c.b, c.d};
                                next_s.cfg1 = {1'b1, 1'b0, c.c, c.a};
                            end
                        end
                        // [R9] original path back
                        CCS_UNSPLIT: begin
                            if (!eb.valid || !eb.split) begin
                                err = CCS_E_NOCONN;
                            end else begin
                                next_s.map[c.b] = {1'b1, 1'b0, eb.orig, eb.orig};
                                next_s.map[c.c] = '0;
                                next_s.cfg0 = {1'b1, 1'b0, c.b, eb.orig};
                                next_s.cfg1 = {1'b1, 1'b1, c.c, 13'h0};
                            end
                        end
                        // [R10] idle on dropped output
                        CCS_DISC: begin
                            if (!eb.valid) begin
                                err = CCS_E_NOCONN;
                            end else begin
                                next_s.map[c.b] = '0;
                                next_s.cfg0 = {1'b1, 1'b1, c.b, 13'h0};
                            end
                        end
                        default: begin
                            err = CCS_E_OP;
                        end
                    endcase
                    // [R4] setup limit check
                    if (err == CCS_OK && el >= lim(c.op, c.sig)) begin
                        err = CCS_E_LATE;
                    end
                end
                // [R11] rejected request leaves map
                if (err != CCS_OK && err != CCS_E_LATE) begin
                    next_s.map  = s.map;
                    next_s.cfg0 = '0;
                    next_s.cfg1 = '0;
                end
                next_s.rsp = {1'b1, c.op, err, el};
            end
            default: begin
                next_s.fsm = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : ccs_switch_ctrl

// ===== sim/ccs_switch_ctrl_sva.sv
// Port checker for the cross-connect switch control
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module ccs_switch_ctrl_sva import ccs_pkg::*; #(
    parameter int SETUP_SLOW = 30,
    parameter int HIT_FAST   = 8
) (
    input wire logic     clk,
    input wire logic     rst_n,
    input wire logic     cmd_valid,
    input wire logic     cmd_ready,
    input wire ccs_cmd_t cmd,
    input wire ccs_rsp_t rsp,
    input wire ccs_cfg_t cfg0,
    input wire ccs_cfg_t cfg1
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Response that writes the fabric
    wire done = rsp.valid && rsp.err inside {CCS_OK, CCS_E_LATE};
    a_rsp_pulse: assert property (
        rsp.valid |=> !rsp.valid) else $error("response pulse too long");
    a_answer_bound: assert property (
        cmd_valid && cmd_ready |-> ##[3:35] rsp.valid) else $error("no response in time");
    a_cfg_cause: assert property (
        cfg0.valid || cfg1.valid |-> done) else $error("fabric write without success");
    a_disc_idle: assert property (
        done && rsp.op == CCS_DISC |-> cfg0.valid && cfg0.idle) else $error("disconnect not idled");
    a_oneway_lane: assert property (
        done && rsp.op == CCS_ONEWAY |-> cfg0.valid && !cfg0.idle && !cfg1.valid) else $error("one-way lanes");
    a_twoway_pair: assert property (
        done && rsp.op == CCS_TWOWAY |-> cfg1.valid && cfg1.out == cfg0.src && cfg1.src == cfg0.out)
        else $error("two-way not paired");
    a_roll_swap: assert property (
        done && rsp.op == CCS_ROLL |-> cfg0.valid && !cfg0.idle) else $error("roll not one step");
    a_setup_bound: assert property (
        rsp.valid && rsp.err == CCS_OK |-> rsp.elapsed < SETUP_SLOW) else $error("setup too slow");
    a_late_flag: assert property (
        rsp.valid && rsp.err == CCS_E_LATE |-> rsp.elapsed >= HIT_FAST) else $error("late flag early");
    a_port_range: assert property (
        cfg0.valid |-> cfg0.out < 13'h1c00 && cfg0.src < 13'h1c00) else $error("port out of range");
endmodule : ccs_switch_ctrl_sva

// ===== sim/ccs_fabric_model.sv
// Fabric model that applies configuration writes
`timescale 1ns/1ps
// ****************
// Fabric model
// ****************
module ccs_fabric_model import ccs_pkg::*; (
    input wire logic     clk,
    input wire ccs_cfg_t cfg0,
    input wire ccs_cfg_t cfg1
);
    logic [12:0] src_of  [0:7167];
    logic        idle_of [0:7167];
    always @(posedge clk) begin
        if (cfg0.valid) begin
            src_of[cfg0.out]  <= cfg0.src;
            idle_of[cfg0.out] <= cfg0.idle;
        end
        if (cfg1.valid) begin
            src_of[cfg1.out]  <= cfg1.src;
            idle_of[cfg1.out] <= cfg1.idle;
        end
    end
endmodule : ccs_fabric_model

// ===== sim/ccs_switch_ctrl_tb.sv
// Testbench for the cross-connect switch control
`timescale 1ns/1ps
// ****************
// Bench top
// ****************
module ccs_switch_ctrl_tb import ccs_pkg::*; ;
    logic     clk, rst_n, cmd_valid, cmd_ready;
    ccs_cmd_t cmd;
    ccs_rsp_t rsp, r;
    ccs_cfg_t cfg0, cfg1, c0, c1;
    int       n_mismatch = 0;
    int       checks = 0;
    ccs_switch_ctrl #(.SETUP_FAST(20), .SETUP_SLOW(30), .HIT_FAST(8), .HIT_SLOW(9), .IDLE_LIM(9)) dut (
        .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp(rsp), .cfg0(cfg0), .cfg1(cfg1));
    ccs_fabric_model fab (.clk(clk), .cfg0(cfg0), .cfg1(cfg1));
    // Compare and count
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic ccs_cfg_t mk(logic [12:0] o, logic [12:0] s, logic i = 1'b0);
        return {1'b1, i, o, s};
    endfunction : mk
    // Offer at falling edge, hold until taken
    task automatic send(ccs_op_t o, ccs_sig_t s, logic [12:0] a, b, c, d);
        cmd_valid = 1'b1;
        cmd = {o, s, a, b, c, d};
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask : send
    // Catch the one-cycle response
    task automatic wait_rsp();
        int n;
        n = 0;
        while (rsp.valid !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (n >= 60) n_mismatch++;
        r = rsp;
        c0 = cfg0;
        c1 = cfg1;
        @(negedge clk);
    endtask : wait_rsp
    task automatic do_op(ccs_op_t o, ccs_sig_t s, logic [12:0] a, b, c, d, ccs_err_t e);
        send(o, s, a, b, c, d);
        cmd_valid = 1'b0;
        wait_rsp();
        chk(64'({r.valid, r.err}), 64'({1'b1, e}));
        if (e === CCS_OK) chk(64'({r.op, r.elapsed}), 64'({o, 32'h2}));
    endtask : do_op
    task automatic t_connect();
        do_op(CCS_ONEWAY, CCS_DS1, 13'h5, 13'h9, '0, '0, CCS_OK);
        chk(64'(c0), 64'(mk(13'h9, 13'h5)));
        do_op(CCS_TWOWAY, CCS_VT15, 13'h14, 13'h15, '0, '0, CCS_OK);
        chk(64'({c0, c1}), 64'({mk(13'h15, 13'h14), mk(13'h14, 13'h15)}));
    endtask : t_connect
    task automatic t_bridge_roll();
        do_op(CCS_BRIDGE, CCS_STS1, 13'h5, 13'h1e, 13'h9, '0, CCS_OK);
        chk(64'({c0, fab.src_of[9]}), 64'({mk(13'h1e, 13'h5), 13'h5}));
        do_op(CCS_ROLL, CCS_DS1, 13'h28, 13'h1e, '0, '0, CCS_OK);
        chk(64'({c0, fab.src_of[9]}), 64'({mk(13'h1e, 13'h28), 13'h5}));
    endtask : t_bridge_roll
    task automatic t_split();
        do_op(CCS_SPLIT, CCS_DS1, 13'h5, 13'h9, 13'h32, 13'h33, CCS_OK);
        chk(64'({fab.src_of[9], fab.src_of[50]}), 64'({13'h33, 13'h5}));
        do_op(CCS_UNSPLIT, CCS_DS1, '0, 13'h9, 13'h32, '0, CCS_OK);
        chk(64'({fab.src_of[9], fab.idle_of[9], fab.idle_of[50]}), 64'({13'h5, 2'b01}));
        do_op(CCS_DISC, CCS_DS1, '0, 13'h1e, '0, '0, CCS_OK);
        chk(64'(c0), 64'(mk(13'h1e, 13'h0, 1'b1)));
    endtask : t_split
    task automatic t_errors();
        do_op(CCS_ONEWAY, CCS_DS1, 13'h1c00, 13'h64, '0, '0, CCS_E_RANGE);
        do_op(CCS_ONEWAY, CCS_DS1, 13'h1bff, 13'h9, '0, '0, CCS_E_BUSY);
        do_op(CCS_ROLL, CCS_DS1, 13'h1, 13'h65, '0, '0, CCS_E_NOCONN);
        do_op(ccs_op_t'(3'h7), CCS_DS1, '0, '0, '0, '0, CCS_E_OP);
        chk(64'(fab.src_of[9]), 64'h5);
        do_op(CCS_ONEWAY, CCS_STS1, 13'h1bff, 13'h1bff, '0, '0, CCS_OK);
    endtask : t_errors
    // Flood the queue past refusal while draining in parallel
    task automatic t_backlog();
        int late;
        bit full;
        late = 0;
        full = 1'b0;
        fork
            begin
                for (int i = 0; i < 40; i++) begin
                    full |= !cmd_ready;
                    send(CCS_ONEWAY, CCS_DS1, 13'(1000 + i), 13'(200 + i), '0, '0);
                end
                cmd_valid = 1'b0;
            end
            for (int k = 0; k < 40; k++) begin
                int el;
                // Queue wait grows by one per request until the queue caps it
                el = (k < 30) ? k + 2 : 32;
                wait_rsp();
                late += int'(r.err === CCS_E_LATE);
                chk(64'(r.err === CCS_E_LATE), 64'(el >= 20));
                chk(64'(r.err), 64'((el >= 20) ? CCS_E_LATE : CCS_OK));
                chk(64'({r.op, r.elapsed}), 64'({CCS_ONEWAY, 32'(el)}));
            end
        join
        chk(64'({full, late > 0}), 64'h3);
    endtask : t_backlog
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_connect();
        t_bridge_roll();
        t_split();
        t_errors();
        t_backlog();
        report_and_stop();
    end
endmodule : ccs_switch_ctrl_tb
bind ccs_switch_ctrl ccs_switch_ctrl_sva #(.SETUP_SLOW(SETUP_SLOW), .HIT_FAST(HIT_FAST)) u_sva (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp(rsp), .cfg0(cfg0), .cfg1(cfg1));
